// ===== hw/sacc_pkg.sv
// Package of constants and types for the SAR converter control block
package sacc_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CHAN = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_PORT = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_FULL = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_SHORT = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
	localparam int MODE_START_BIT = 7;
	localparam int MODE_ENABLE_BIT = 0;
	localparam int MODE_TIME_LSB = 1;
	localparam int MODE_TIME_W = 6;
	localparam int CHAN_W = 3;
	localparam int PORT_W = 4;
	localparam int RES_W = 10;
	localparam int FULL_W = 16;
	localparam int SHORT_W = 8;
	localparam int FULL_SHIFT = 6;
	localparam int IRQ_W = 2;
	localparam int IRQ_END_BIT = 0;
	localparam int IRQ_SUSPECT_BIT = 1;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [CHAN_W-1:0] CHAN_RST = 3'h0;
	localparam logic [PORT_W-1:0] PORT_RST = 4'h0;
	localparam logic [FULL_W-1:0] FULL_RST = 16'h0000;
	localparam logic [SHORT_W-1:0] SHORT_RST = 8'h00;
	localparam int CLK_MHZ = 40;
	localparam int SETTLE_NS = 1000;
	localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int SAMPLE_CYC = 8;
	localparam int BIT_CYC = 2;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum {SEQ_IDLE, SEQ_SAMPLE, SEQ_CONVERT} sacc_seq_t;
	typedef struct packed {
		logic start;
		logic [MODE_TIME_W-1:0] time_sel;
		logic enable;
	} sacc_mode_t;
	typedef struct packed {
		logic [FULL_W-1:0] full;
		logic [SHORT_W-1:0] short_r;
	} sacc_result_t;
endpackage

// ===== hw/sacc_sar_seq.sv
// Successive-approximation sequencer: sampling, bit trials, result pulse
`timescale 1ns/100ps
`default_nettype none
module sacc_sar_seq
	import sacc_pkg::*;
#(
	parameter int RES_BITS = RES_W
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic run_i,
	input wire logic restart_i,
	input wire logic [MODE_TIME_W-1:0] time_sel_i,
	input wire logic cmp_i,
	output logic sample_o,
	output logic busy_o,
	output logic [RES_BITS-1:0] trial_o,
	output logic done_o,
	output logic [RES_BITS-1:0] value_o
);
	sacc_seq_t state_q;
	logic [7:0] cnt_q;
	logic [3:0] bit_q;
	logic [RES_BITS-1:0] sar_q;
	logic [7:0] bit_len;

	// Slower time selections stretch each bit trial
	assign bit_len = 8'(BIT_CYC) + {2'h0, time_sel_i};
	assign sample_o = (state_q == SEQ_SAMPLE);
	assign busy_o = (state_q != SEQ_IDLE);
	assign trial_o = sar_q;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_q <= SEQ_IDLE;
			cnt_q <= 8'h00;
			bit_q <= 4'h0;
			sar_q <= '0;
			done_o <= 1'b0;
			value_o <= '0;
		end
		else
		begin
			done_o <= 1'b0;
			if (!run_i || restart_i)
			begin
				// Abort drops partial work; restart resamples
				state_q <= (run_i) ? SEQ_SAMPLE : SEQ_IDLE;
				cnt_q <= 8'h00;
				sar_q <= '0;
			end
			else
			begin
				case (state_q)
				SEQ_IDLE:
				begin
					state_q <= SEQ_SAMPLE;
					cnt_q <= 8'h00;
				end
				SEQ_SAMPLE:
				begin
					// Sampling is part of the counted conversion time
					if (cnt_q == 8'(SAMPLE_CYC - 1))
					begin
						state_q <= SEQ_CONVERT;
						cnt_q <= 8'h00;
						bit_q <= 4'(RES_BITS - 1);
						sar_q <= '0;
						sar_q[RES_BITS-1] <= 1'b1;
					end
					else
						cnt_q <= cnt_q + 8'h01;
				end
				SEQ_CONVERT:
				begin
					if (cnt_q == bit_len - 8'h01)
					begin
						cnt_q <= 8'h00;
						if (!cmp_i)
							sar_q[bit_q] <= 1'b0;
						if (bit_q == 4'h0)
						begin
							done_o <= 1'b1;
							value_o <= cmp_i ? sar_q : (sar_q & ~RES_BITS'(1));
							// Back-to-back conversions
							state_q <= SEQ_SAMPLE;
						end
						else
						begin
							bit_q <= bit_q - 4'h1;
							sar_q[bit_q - 4'h1] <= 1'b1;
						end
					end
					else
						cnt_q <= cnt_q + 8'h01;
				end
				default: state_q <= SEQ_IDLE;
				endcase
			end
		end
	end
endmodule // sacc_sar_seq
`default_nettype wire

// ===== hw/sacc_top.sv
// Converter control top: AXI4-Lite registers, conflict handling, interrupt
`timescale 1ns/100ps
`default_nettype none
module sacc_top
	import sacc_pkg::*;
(
	input wire logic REF_CLK_I,
	input wire logic RST_N_I,
	input wire logic STOP_MODE_I,
	input wire logic CMP_I,
	input wire logic [ADDR_W-1:0] AWADDR_I,
	input wire logic AWVALID_I,
	output logic AWREADY_O,
	input wire logic [DATA_W-1:0] WDATA_I,
	input wire logic [3:0] WSTRB_I,
	input wire logic WVALID_I,
	output logic WREADY_O,
	output logic [1:0] BRESP_O,
	output logic BVALID_O,
	input wire logic BREADY_I,
	input wire logic [ADDR_W-1:0] ARADDR_I,
	input wire logic ARVALID_I,
	output logic ARREADY_O,
	output logic [DATA_W-1:0] RDATA_O,
	output logic [1:0] RRESP_O,
	output logic RVALID_O,
	input wire logic RREADY_I,
	output logic SAMPLE_O,
	output logic [CHAN_W-1:0] CHAN_O,
	output logic [RES_W-1:0] TRIAL_O,
	output logic IRQ_O
);
	sacc_mode_t mode_q;
	logic [CHAN_W-1:0] chan_q;
	logic [PORT_W-1:0] port_q;
	sacc_result_t res_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_en_q;
	logic aw_hold_q;
	logic w_hold_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [DATA_W-1:0] w_data_q;
	logic [3:0] w_strb_q;
	logic pend_q;
	logic [RES_W-1:0] pend_val_q;
	logic [7:0] settle_q;
	logic first_q;
	logic wr_go;
	logic rd_go;
	logic cfg_wr;
	logic chan_wr;
	logic res_rd;
	logic run;
	logic seq_sample;
	logic seq_busy;
	logic [RES_W-1:0] seq_trial;
	logic seq_done;
	logic [RES_W-1:0] seq_value;
	logic store;
	logic [DATA_W-1:0] rd_word;
	logic rd_ok;

	// Write happens once both halves have arrived and no response is pending
	assign wr_go = aw_hold_q && w_hold_q && !BVALID_O;
	assign rd_go = ARVALID_I && ARREADY_O;
	assign cfg_wr = wr_go && w_strb_q[0] && (aw_addr_q == OFS_MODE
		|| aw_addr_q == OFS_CHAN || aw_addr_q == OFS_PORT);
	assign chan_wr = wr_go && w_strb_q[0] && (aw_addr_q == OFS_CHAN);
	assign res_rd = rd_go && (ARADDR_I == OFS_FULL || ARADDR_I == OFS_SHORT);
	// Standby gates the sequencer entirely
	assign run = mode_q.start && !STOP_MODE_I;

	sacc_sar_seq #(
		.RES_BITS(RES_W)
	) u_seq (
		.clk_i(REF_CLK_I),
		.rst_n_i(RST_N_I),
		.run_i(run),
		.restart_i(chan_wr),
		.time_sel_i(mode_q.time_sel),
		.cmp_i(CMP_I),
		.sample_o(seq_sample),
		.busy_o(seq_busy),
		.trial_o(seq_trial),
		.done_o(seq_done),
		.value_o(seq_value)
	);

	// Result stored one cycle after done, unless held off by a read or dropped by a config write
	assign store = pend_q && !res_rd && !cfg_wr;

	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			AWREADY_O <= 1'b0;
			WREADY_O <= 1'b0;
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= 4'h0;
		end
		else
		begin
			AWREADY_O <= !aw_hold_q && !AWVALID_I;
			WREADY_O <= !w_hold_q && !WVALID_I;
			if (AWVALID_I && AWREADY_O)
			begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= AWADDR_I;
				AWREADY_O <= 1'b0;
			end
			if (WVALID_I && WREADY_O)
			begin
				w_hold_q <= 1'b1;
				w_data_q <= WDATA_I;
				w_strb_q <= WSTRB_I;
				WREADY_O <= 1'b0;
			end
			if (wr_go)
			begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				AWREADY_O <= 1'b1;
				WREADY_O <= 1'b1;
			end
			else if (aw_hold_q || (AWVALID_I && AWREADY_O))
				AWREADY_O <= 1'b0;
			else
				AWREADY_O <= 1'b1;
			if (!wr_go && (w_hold_q || (WVALID_I && WREADY_O)))
				WREADY_O <= 1'b0;
			else
				WREADY_O <= 1'b1;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			BVALID_O <= 1'b0;
			BRESP_O <= RESP_OKAY;
		end
		else if (wr_go)
		begin
			BVALID_O <= 1'b1;
			BRESP_O <= (aw_addr_q > OFS_STATUS || aw_addr_q[1:0] != 2'b00)
				? RESP_SLVERR : RESP_OKAY;
		end
		else if (BREADY_I)
			BVALID_O <= 1'b0;
	end

	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			mode_q <= MODE_RST;
			chan_q <= CHAN_RST;
			port_q <= PORT_RST;
			irq_en_q <= '0;
		end
		else if (wr_go && w_strb_q[0])
		begin
			case (aw_addr_q)
			OFS_MODE: mode_q <= w_data_q[7:0];
			OFS_CHAN: chan_q <= w_data_q[CHAN_W-1:0];
			OFS_PORT: port_q <= w_data_q[PORT_W-1:0];
			OFS_IRQ_EN: irq_en_q <= w_data_q[IRQ_W-1:0];
			default: ;
			endcase
		end
	end

	// Pending holder delays a result by one cycle past a colliding read
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			pend_q <= 1'b0;
			pend_val_q <= '0;
		end
		else
		begin
			if (seq_done)
			begin
				pend_q <= 1'b1;
				pend_val_q <= seq_value;
			end
			else if (store || cfg_wr)
				pend_q <= 1'b0;
		end
	end

	// Both result registers change in the same cycle
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			res_q <= {FULL_RST, SHORT_RST};
		else if (store)
		begin
			res_q.full <= {pend_val_q, FULL_SHIFT'(0)};
			res_q.short_r <= pend_val_q[RES_W-1 -: SHORT_W];
		end
	end

	// Settling after enable; a start too early marks next result
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			settle_q <= 8'h00;
			first_q <= 1'b0;
		end
		else
		begin
			if (!mode_q.enable)
				settle_q <= 8'h00;
			else if (settle_q != 8'(SETTLE_CYC))
				settle_q <= settle_q + 8'h01;
			if (run && !seq_busy && !first_q)
				first_q <= (settle_q != 8'(SETTLE_CYC));
			else if (store)
				first_q <= 1'b0;
		end
	end

	// Set wins over clear; a channel write in the store cycle drops the result, so the flag is not set
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			irq_stat_q <= '0;
		else
		begin
			if (wr_go && w_strb_q[0] && aw_addr_q == OFS_IRQ_CLR)
				irq_stat_q <= irq_stat_q & ~w_data_q[IRQ_W-1:0];
			if (store)
			begin
				irq_stat_q[IRQ_END_BIT] <= 1'b1;
				if (first_q)
					irq_stat_q[IRQ_SUSPECT_BIT] <= 1'b1;
			end
		end
	end

	always_comb
	begin
		rd_word = '0;
		rd_ok = 1'b1;
		case (ARADDR_I)
		OFS_MODE: rd_word[7:0] = mode_q;
		OFS_CHAN: rd_word[CHAN_W-1:0] = chan_q;
		OFS_PORT: rd_word[PORT_W-1:0] = port_q;
		OFS_FULL: rd_word[FULL_W-1:0] = res_q.full;
		OFS_SHORT: rd_word[SHORT_W-1:0] = res_q.short_r;
		OFS_IRQ_STAT: rd_word[IRQ_W-1:0] = irq_stat_q;
		OFS_IRQ_EN: rd_word[IRQ_W-1:0] = irq_en_q;
		OFS_IRQ_CLR: rd_word = '0;
		OFS_STATUS: rd_word[1:0] = {first_q, seq_busy};
		default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			ARREADY_O <= 1'b0;
			RVALID_O <= 1'b0;
			RDATA_O <= '0;
			RRESP_O <= RESP_OKAY;
		end
		else
		begin
			ARREADY_O <= !RVALID_O && !rd_go;
			if (rd_go)
			begin
				RVALID_O <= 1'b1;
				RDATA_O <= rd_word;
				RRESP_O <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (RREADY_I && RVALID_O)
			begin
				RVALID_O <= 1'b0;
				ARREADY_O <= 1'b1;
			end
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			SAMPLE_O <= 1'b0;
			CHAN_O <= CHAN_RST;
			TRIAL_O <= '0;
			IRQ_O <= 1'b0;
		end
		else
		begin
			SAMPLE_O <= seq_sample && run;
			CHAN_O <= chan_q;
			TRIAL_O <= seq_trial;
			IRQ_O <= |(irq_stat_q & irq_en_q);
		end
	end
endmodule // sacc_top
`default_nettype wire

// ===== dv/sacc_properties.sv
// Port checker of the converter control block
`timescale 1ns/100ps
`default_nettype none
module sacc_properties
	import sacc_pkg::*;
(
	input wire logic REF_CLK_I,
	input wire logic RST_N_I,
	input wire logic STOP_MODE_I,
	input wire logic [ADDR_W-1:0] AWADDR_I,
	input wire logic AWVALID_I,
	input wire logic AWREADY_O,
	input wire logic [DATA_W-1:0] WDATA_I,
	input wire logic WVALID_I,
	input wire logic WREADY_O,
	input wire logic BVALID_O,
	input wire logic [ADDR_W-1:0] ARADDR_I,
	input wire logic ARVALID_I,
	input wire logic ARREADY_O,
	input wire logic [DATA_W-1:0] RDATA_O,
	input wire logic [1:0] RRESP_O,
	input wire logic RVALID_O,
	input wire logic SAMPLE_O,
	input wire logic IRQ_O
);
	// Ten trials at the slowest time select, plus storing
	localparam int GAP_MAX = 700;
	logic [ADDR_W-1:0] wa_q, ra_q;
	logic [7:0] wd_q;
	logic bv_q, go_q, en_q, quiet;
	int gap_q;
	// Writes count only once the bus is quiet, since we mirror them late
	assign quiet = !AWVALID_I && !WVALID_I;
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RST_N_I);
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
		if (!RST_N_I)
		begin
			{wa_q, ra_q, wd_q, bv_q, go_q, en_q} <= '0;
			gap_q <= 0;
		end
		else
		begin
			bv_q <= BVALID_O;
			if (AWVALID_I && AWREADY_O) wa_q <= AWADDR_I;
			if (WVALID_I && WREADY_O) wd_q <= WDATA_I[7:0];
			if (ARVALID_I && ARREADY_O) ra_q <= ARADDR_I;
			if (BVALID_O && !bv_q && wa_q == OFS_MODE) go_q <= wd_q[7];
			if (BVALID_O && !bv_q && wa_q == OFS_IRQ_EN) en_q <= |wd_q[1:0];
			if (SAMPLE_O || !go_q || STOP_MODE_I || !quiet) gap_q <= 0;
			else gap_q <= gap_q + 1;
		end
	a_stop_halts: assert property (STOP_MODE_I [*3] |-> !SAMPLE_O)
		else $error("sampling in standby");
	a_clear_stops: assert property ((!go_q && quiet) [*4] |-> !SAMPLE_O)
		else $error("sampling while stopped");
	a_chan_restart: assert property (BVALID_O && !bv_q && wa_q == OFS_CHAN
		&& go_q && !STOP_MODE_I |-> ##[0:4] SAMPLE_O)
		else $error("no restart");
	a_runs_again: assert property (gap_q < GAP_MAX)
		else $error("no next conversion");
	a_full_align: assert property (RVALID_O && ra_q == OFS_FULL |->
		RDATA_O[5:0] == 6'h00 && RDATA_O[31:16] == 16'h0000)
		else $error("full layout");
	a_short_width: assert property (RVALID_O && ra_q == OFS_SHORT |->
		RDATA_O[31:8] == 24'h000000)
		else $error("short layout");
	a_read_resp: assert property (RVALID_O |-> RRESP_O == ((ra_q > OFS_STATUS
		|| ra_q[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY))
		else $error("read response");
	a_irq_masked: assert property ((!en_q && quiet) [*4] |-> !IRQ_O)
		else $error("masked interrupt");
	c_irq: cover property ($rose(IRQ_O));
	c_full: cover property (RVALID_O && ra_q == OFS_FULL);
	c_stop: cover property (STOP_MODE_I && go_q);
endmodule // sacc_properties
bind sacc_top sacc_properties u_props (.REF_CLK_I, .RST_N_I, .STOP_MODE_I,
	.AWADDR_I, .AWVALID_I, .AWREADY_O, .WDATA_I, .WVALID_I, .WREADY_O,
	.BVALID_O, .ARADDR_I, .ARVALID_I, .ARREADY_O, .RDATA_O, .RRESP_O,
	.RVALID_O, .SAMPLE_O, .IRQ_O);
`default_nettype wire

// ===== dv/test_sar_adc_conflict_control.sv
// Self-checking bench of the converter control block
`timescale 1ns/100ps
`default_nettype none
module test_sar_adc_conflict_control
	import sacc_pkg::*;
;
	logic clk, rst_n, stop, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, sample, irq;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [DATA_W-1:0] wdata, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic [CHAN_W-1:0] chan;
	logic [RES_W-1:0] trial;
	int err_count, comparisons, tgt, v, n;
	int unsigned seed;
	int hist[$];
	// Ideal comparator: a trial tap is kept while the input reaches it
	wire logic cmp = tgt >= int'(trial);
	sacc_top DUT (.REF_CLK_I(clk), .RST_N_I(rst_n), .STOP_MODE_I(stop),
		.CMP_I(cmp), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
		.AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hF),
		.WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
		.BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr),
		.ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
		.RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
		.SAMPLE_O(sample), .CHAN_O(chan), .TRIAL_O(trial), .IRQ_O(irq));
	function automatic int unsigned xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string s, input logic [31:0] e, g);
		comparisons++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge clk);
		awaddr <= a;
		wdata <= x;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end
		while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic wirq();
		n = 0;
		// Registered output still shows a just-cleared flag for two edges
		repeat (2) @(posedge clk);
		while (irq !== 1'b1 && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		tally_and_finish();
	end
	initial
	begin
		{rst_n, stop, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		seed = 65065;
		tgt = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFS_FULL);
		chk("full", {16'h0, FULL_RST}, d);
		rd(OFS_SHORT);
		chk("short", {24'h0, SHORT_RST}, d);
		rd(8'h44);
		chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
		wr(8'h44, 32'h1);
		chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
		$display("reset done");
		wr(OFS_IRQ_EN, 32'h1);
		wr(OFS_MODE, 32'h07);
		repeat (SETTLE_CYC + 4) @(posedge clk);
		wr(OFS_MODE, 32'h87);
		for (int i = 0; i < 3; i++)
		begin
			v = int'(xs() % 1024);
			hist.push_back(v);
			tgt <= v;
			wr(OFS_CHAN, 32'(i + 1));
			wr(OFS_IRQ_CLR, 32'h1);
			chk("chan", 32'(i + 1), {29'h0, chan});
			wirq();
			rd(OFS_FULL);
			chk("full", 32'(hist[$]) << FULL_SHIFT, d);
			rd(OFS_SHORT);
			chk("short", 32'(hist[$]) >> 2, d);
		end
		wr(OFS_CHAN, 32'h2);
		rd(OFS_IRQ_STAT);
		chk("flag", 32'h1, d & 32'h1);
		wr(OFS_IRQ_EN, 32'h0);
		repeat (3) @(posedge clk);
		chk("irq", 32'h0, {31'h0, irq});
		wr(OFS_IRQ_EN, 32'h1);
		repeat (3) @(posedge clk);
		chk("irq", 32'h1, {31'h0, irq});
		wr(OFS_IRQ_CLR, 32'h1);
		repeat (3) @(posedge clk);
		chk("irq", 32'h0, {31'h0, irq});
		$display("conversion done");
		v = hist[$] ^ 32'h155;
		hist.push_back(v);
		tgt <= v;
		wr(OFS_CHAN, 32'h1);
		// Store comes 60 edges after a restart: 8 sample, 10 x 5 trial, 2
		repeat (56) @(posedge clk);
		wr(OFS_PORT, 32'h5);
		rd(OFS_IRQ_STAT);
		chk("dropped flag", 32'h0, d & 32'h1);
		rd(OFS_FULL);
		chk("dropped", 32'(hist[$-1]) << FULL_SHIFT, d);
		wr(OFS_CHAN, 32'h1);
		repeat (57) @(posedge clk);
		rd(OFS_FULL);
		chk("read first", 32'(hist[$-1]) << FULL_SHIFT, d);
		rd(OFS_FULL);
		chk("written after", 32'(hist[$]) << FULL_SHIFT, d);
		rd(OFS_SHORT);
		chk("short after", 32'(hist[$]) >> 2, d);
		wr(OFS_IRQ_CLR, 32'h1);
		$display("collision done");
		wr(OFS_MODE, 32'h07);
		tgt <= hist[$] ^ 32'h3FF;
		repeat (150) @(posedge clk);
		rd(OFS_FULL);
		chk("full kept", 32'(hist[$]) << FULL_SHIFT, d);
		wr(OFS_MODE, 32'h06);
		wr(OFS_MODE, 32'h86);
		wirq();
		rd(OFS_IRQ_STAT);
		chk("suspect", 32'h2, d & 32'h2);
		$display("stop done");
		stop <= 1'b1;
		wr(OFS_IRQ_CLR, 32'h3);
		repeat (200) @(posedge clk);
		rd(OFS_IRQ_STAT);
		chk("standby", 32'h0, d & 32'h1);
		wr(OFS_MODE, 32'h00);
		stop <= 1'b0;
		wr(OFS_MODE, 32'h87);
		wirq();
		chk("resume", 32'h1, {31'h0, irq});
		$display("standby done");
		tally_and_finish();
	end
endmodule // test_sar_adc_conflict_control
`default_nettype wire
